// file: hw/area_cfg_pkg.sv
package area_cfg_pkg;

	// ----------------------------------------------------------------
	// Register offsets, widths and reset values
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_WIDTH = 4;
	localparam int unsigned DATA_WIDTH = 8;
	localparam int unsigned NUM_AREAS = 8;

	localparam logic [3:0] BUS_WIDTH_OFFSET = 4'h0;
	localparam logic [3:0] ACCESS_STATES_OFFSET = 4'h1;
	localparam logic [3:0] WAIT_HIGH_OFFSET = 4'h2;
	localparam logic [3:0] WAIT_LOW_OFFSET = 4'h3;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	localparam logic [7:0] BUS_WIDTH_RESET_MODE_5_TO_7 = 8'hFF;
	localparam logic [7:0] BUS_WIDTH_RESET_MODE_4 = 8'h00;
	localparam logic [7:0] ACCESS_STATES_RESET = 8'hFF;
	localparam logic [7:0] WAIT_HIGH_RESET = 8'hFF;
	localparam logic [7:0] WAIT_LOW_RESET = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// Operating mode strap code that selects 16-bit default width
	localparam logic [2:0] MODE_WIDE_DEFAULT = 3'h4;

	// Field widths and fixed internal access figures
	localparam int unsigned WAIT_FIELD_WIDTH = 2;
	localparam logic [1:0] STATES_TWO = 2'h2;
	localparam logic [1:0] STATES_THREE = 2'h3;
	localparam logic [1:0] INTERNAL_STATES = 2'h2;
	localparam logic [1:0] NO_WAITS = 2'h0;

	// Wait field positions inside the high and low wait registers
	localparam int unsigned AREA7_WAIT_LSB_POS = 6;
	localparam int unsigned AREA6_WAIT_LSB_POS = 4;
	localparam int unsigned AREA5_WAIT_LSB_POS = 2;
	localparam int unsigned AREA4_WAIT_LSB_POS = 0;

	// Status register field positions
	localparam int unsigned STATUS_MODE_LSB_POS = 0;
	localparam int unsigned STATUS_STANDBY_POS = 3;

endpackage : area_cfg_pkg

// file: hw/external_area_access_config.sv
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module external_area_access_config
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_hw_standby,
	input wire logic i_manual_reset,
	input wire logic i_sw_standby,
	input wire logic [2:0] i_mode,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [2:0] i_access_area,
	input wire logic i_access_external,
	input wire logic i_wait_request,
	output logic [7:0] o_rdata,
	output logic [7:0] o_area_width_bits,
	output logic [7:0] o_area_state_bits,
	output logic o_access_8bit,
	output logic [1:0] o_access_states,
	output logic [1:0] o_access_waits,
	output logic o_wait_pin_enable
);

	// ----------------------------------------------------------------
	// Initialising event and mode strap capture
	// ----------------------------------------------------------------

	// Hardware standby initialises like a power-on reset, but it is a
	// pin from outside, so it passes three flops before it is trusted.
	logic [2:0] standby_sync_ff;
	logic standby_active_ff;
	logic [2:0] mode_meta_ff;
	logic [2:0] mode_mid_ff;
	logic [2:0] mode_last_ff;
	logic [2:0] mode_ff;
	logic init_pulse;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			standby_sync_ff <= 3'h0;
		end
		else
		begin
			standby_sync_ff <= {standby_sync_ff[1:0], i_hw_standby};
		end
	end

	// Change counts only once the second and third stages agree
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			standby_active_ff <= 1'b0;
		end
		else if (standby_sync_ff[1] == standby_sync_ff[2])
		begin
			standby_active_ff <= standby_sync_ff[2];
		end
	end

	// The mode strap is a pin as well; three stages with no reset, so they fill while reset is held
	always_ff @(posedge i_clk)
	begin
		mode_meta_ff <= i_mode;
		mode_mid_ff <= mode_meta_ff;
		mode_last_ff <= mode_mid_ff;
	end

	// Strap change counts once the second and third stages agree
	always_ff @(posedge i_clk)
	begin
		if (mode_mid_ff == mode_last_ff)
		begin
			mode_ff <= mode_last_ff;
		end
	end

	// Power-on reset marker: first clock after release loads mode-dependent defaults
	logic por_pending_ff;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			por_pending_ff <= 1'b1;
		end
		else
		begin
			por_pending_ff <= 1'b0;
		end
	end

	// Manual reset and software standby are deliberately not decoded here
	assign init_pulse = por_pending_ff | standby_active_ff;

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	logic wr_width;
	logic wr_states;
	logic wr_wait_high;
	logic wr_wait_low;

	assign wr_width = i_wr && (i_addr == area_cfg_pkg::BUS_WIDTH_OFFSET);
	assign wr_states = i_wr && (i_addr == area_cfg_pkg::ACCESS_STATES_OFFSET);
	assign wr_wait_high = i_wr && (i_addr == area_cfg_pkg::WAIT_HIGH_OFFSET);
	assign wr_wait_low = i_wr && (i_addr == area_cfg_pkg::WAIT_LOW_OFFSET);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0] area_bus_width_ff;
	logic [7:0] area_access_states_ff;
	logic [7:0] area_wait_count_high_ff;
	logic [7:0] area_wait_count_low_ff;
	logic [7:0] width_default;

	// Mode 4 boots external areas at 16 bits, every other mode at 8 bits
	always_comb
	begin
		if (mode_ff == area_cfg_pkg::MODE_WIDE_DEFAULT)
		begin
			width_default = area_cfg_pkg::BUS_WIDTH_RESET_MODE_4;
		end
		else
		begin
			width_default = area_cfg_pkg::BUS_WIDTH_RESET_MODE_5_TO_7;
		end
	end

	// Asynchronous reset loads the all-8-bit value; the mode default lands one edge later
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			area_bus_width_ff <= area_cfg_pkg::BUS_WIDTH_RESET_MODE_5_TO_7;
		end
		else if (init_pulse)
		begin
			area_bus_width_ff <= width_default;
		end
		else if (wr_width)
		begin
			area_bus_width_ff <= i_wdata;
		end
	end

	// Access state register
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			area_access_states_ff <= area_cfg_pkg::ACCESS_STATES_RESET;
		end
		else if (init_pulse)
		begin
			area_access_states_ff <= area_cfg_pkg::ACCESS_STATES_RESET;
		end
		else if (wr_states)
		begin
			area_access_states_ff <= i_wdata;
		end
	end

	// High wait register, areas 7 to 4
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			area_wait_count_high_ff <= area_cfg_pkg::WAIT_HIGH_RESET;
		end
		else if (init_pulse)
		begin
			area_wait_count_high_ff <= area_cfg_pkg::WAIT_HIGH_RESET;
		end
		else if (wr_wait_high)
		begin
			area_wait_count_high_ff <= i_wdata;
		end
	end

	// Low wait register, areas 3 to 0
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			area_wait_count_low_ff <= area_cfg_pkg::WAIT_LOW_RESET;
		end
		else if (init_pulse)
		begin
			area_wait_count_low_ff <= area_cfg_pkg::WAIT_LOW_RESET;
		end
		else if (wr_wait_low)
		begin
			area_wait_count_low_ff <= i_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Read data and status
	// ----------------------------------------------------------------
	logic [7:0] status_value;
	logic [7:0] nxt_rdata;
	logic [7:0] rdata_ff;
	logic wait_seen_ff;

	// Status: bit 4 wait request seen, bit 3 standby active, bits 2:0 settled mode strap
	assign status_value = {3'h0, wait_seen_ff, standby_active_ff, mode_ff};

	// Reads return in the following cycle; unmapped offsets read zero
	always_comb
	begin
		nxt_rdata = area_cfg_pkg::UNMAPPED_READ_VALUE;
		case (i_addr)
			area_cfg_pkg::BUS_WIDTH_OFFSET: nxt_rdata = area_bus_width_ff;
			area_cfg_pkg::ACCESS_STATES_OFFSET: nxt_rdata = area_access_states_ff;
			area_cfg_pkg::WAIT_HIGH_OFFSET: nxt_rdata = area_wait_count_high_ff;
			area_cfg_pkg::WAIT_LOW_OFFSET: nxt_rdata = area_wait_count_low_ff;
			area_cfg_pkg::STATUS_OFFSET: nxt_rdata = status_value;
			default: nxt_rdata = area_cfg_pkg::UNMAPPED_READ_VALUE;
		endcase
	end

	// Data held only in the cycle after a read strobe
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rdata_ff <= 8'h00;
		end
		else if (i_rd)
		begin
			rdata_ff <= nxt_rdata;
		end
		else
		begin
			rdata_ff <= 8'h00;
		end
	end

	assign o_rdata = rdata_ff;

	// ----------------------------------------------------------------
	// Per-area view for the bus cycle generator
	// ----------------------------------------------------------------
	logic [15:0] wait_fields;
	logic [1:0] area_wait;
	logic area_width_bit;
	logic area_state_bit;

	// Area 7 sits in the top field of the high register, area 0 in the bottom of the low one
	assign wait_fields = {area_wait_count_high_ff, area_wait_count_low_ff};
	assign area_wait = wait_fields[{i_access_area, 1'b0} +: area_cfg_pkg::WAIT_FIELD_WIDTH];
	assign area_width_bit = area_bus_width_ff[i_access_area];
	assign area_state_bit = area_access_states_ff[i_access_area];

	// Registered outputs pick up a write on the edge after it, so the next access sees it
	logic access_8bit_ff;
	logic [1:0] access_states_ff;
	logic [1:0] access_waits_ff;
	logic wait_pin_enable_ff;

	// Internal accesses keep the fixed 16-bit, 2-state, no-wait profile
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			access_8bit_ff <= 1'b0;
			access_states_ff <= area_cfg_pkg::INTERNAL_STATES;
			access_waits_ff <= area_cfg_pkg::NO_WAITS;
			wait_pin_enable_ff <= 1'b0;
		end
		else if (!i_access_external)
		begin
			access_8bit_ff <= 1'b0;
			access_states_ff <= area_cfg_pkg::INTERNAL_STATES;
			access_waits_ff <= area_cfg_pkg::NO_WAITS;
			wait_pin_enable_ff <= 1'b0;
		end
		else
		begin
			access_8bit_ff <= area_width_bit;
			access_states_ff <= area_state_bit ? area_cfg_pkg::STATES_THREE : area_cfg_pkg::STATES_TWO;
			access_waits_ff <= area_state_bit ? area_wait : area_cfg_pkg::NO_WAITS;
			wait_pin_enable_ff <= area_state_bit;
		end
	end

	assign o_area_width_bits = area_bus_width_ff;
	assign o_area_state_bits = area_access_states_ff;
	assign o_access_8bit = access_8bit_ff;
	assign o_access_states = access_states_ff;
	assign o_access_waits = access_waits_ff;
	// Pure register state: reading the wait pin here would close a loop through the far side's gating
	assign o_wait_pin_enable = wait_pin_enable_ff;

	// ----------------------------------------------------------------
	// External wait request observation
	// ----------------------------------------------------------------

	// The wait pin comes from outside the clock's domain, so it passes three flops like standby.
	// Stretching the cycle is left to the cycle generator; the bank only reports the request.
	logic [2:0] wait_sync_ff;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wait_sync_ff <= 3'h0;
		end
		else
		begin
			wait_sync_ff <= {wait_sync_ff[1:0], i_wait_request};
		end
	end

	// A request counts only while the presented access is a 3-state external one
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wait_seen_ff <= 1'b0;
		end
		else if (wait_sync_ff[1] == wait_sync_ff[2])
		begin
			wait_seen_ff <= wait_sync_ff[2] & wait_pin_enable_ff;
		end
	end

endmodule : external_area_access_config

// file: test/area_cfg_chk.sv
`timescale 1ns/1ps
// Port-level checker for the area configuration bank
module area_cfg_chk
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_hw_standby,
	input wire logic i_manual_reset,
	input wire logic i_sw_standby,
	input wire logic [2:0] i_mode,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [2:0] i_access_area,
	input wire logic i_access_external,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_area_width_bits,
	input wire logic [7:0] o_area_state_bits,
	input wire logic o_access_8bit,
	input wire logic [1:0] o_access_states,
	input wire logic [1:0] o_access_waits,
	input wire logic o_wait_pin_enable
);
	logic [2:0] quiet_ff;
	// Standby passes a synchroniser, so writes are trusted only after it settles
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			quiet_ff <= 3'h0;
		else if (i_hw_standby)
			quiet_ff <= 3'h0;
		else if (quiet_ff != 3'h7)
			quiet_ff <= quiet_ff + 3'h1;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_release; $fell(i_reset); endsequence
	sequence s_mode_load; o_area_width_bits == (i_mode == 3'h4 ? 8'h00 : 8'hFF); endsequence
	sequence s_ext; !$past(i_reset) && $past(i_access_external); endsequence
	sequence s_int; !$past(i_reset) && !$past(i_access_external); endsequence
	a_reset_load: assert property (s_release |-> o_area_state_bits == 8'hFF ##1 s_mode_load)
		else $error("defaults wrong after reset");
	a_width_select: assert property (s_ext |-> o_access_8bit == $past(o_area_width_bits[i_access_area]))
		else $error("access width wrong");
	a_state_count: assert property (s_ext |-> o_access_states == ($past(o_area_state_bits[i_access_area]) ? 2'h3 : 2'h2)
		&& o_wait_pin_enable == $past(o_area_state_bits[i_access_area]))
		else $error("state count wrong");
	a_wait_gated: assert property (s_ext ##0 !$past(o_area_state_bits[i_access_area]) |-> o_access_waits == 2'h0)
		else $error("waits on 2-state area");
	a_internal_fixed: assert property (s_int |-> !o_access_8bit && o_access_states == 2'h2
		&& o_access_waits == 2'h0 && !o_wait_pin_enable)
		else $error("internal access not fixed");
	a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside slot");
	a_state_read: assert property (i_rd && i_addr == 4'h1 |=> o_rdata == $past(o_area_state_bits))
		else $error("state readback wrong");
	a_state_write: assert property (i_wr && i_addr == 4'h1 && !i_hw_standby && quiet_ff == 3'h7
		|=> o_area_state_bits == $past(i_wdata))
		else $error("state write lost");
	a_soft_retain: assert property ((i_manual_reset || i_sw_standby) && !i_wr && !i_hw_standby && quiet_ff == 3'h7
		|=> $stable(o_area_width_bits) && $stable(o_area_state_bits))
		else $error("contents lost on soft reset");
endmodule : area_cfg_chk

bind external_area_access_config area_cfg_chk chk (.i_clk(i_clk), .i_reset(i_reset), .i_hw_standby(i_hw_standby),
	.i_manual_reset(i_manual_reset), .i_sw_standby(i_sw_standby), .i_mode(i_mode), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_access_area(i_access_area),
	.i_access_external(i_access_external), .o_rdata(o_rdata), .o_area_width_bits(o_area_width_bits),
	.o_area_state_bits(o_area_state_bits), .o_access_8bit(o_access_8bit), .o_access_states(o_access_states),
	.o_access_waits(o_access_waits), .o_wait_pin_enable(o_wait_pin_enable));

// file: test/ext_bus_model.sv
`timescale 1ns/1ps
// Slow external peripheral on the area bus
module ext_bus_model
(
	input wire logic i_wait_pin_enable,
	input wire logic i_slow,
	output logic o_wait_request
);
	// Stretches only 3-state external areas; otherwise the line rests low
	assign o_wait_request = i_wait_pin_enable & i_slow;
endmodule : ext_bus_model

// file: test/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the area configuration bank
module tb;
	logic i_clk = 1'b0, i_reset = 1'b1, i_hw_standby = 1'b0, i_manual_reset = 1'b0, i_sw_standby = 1'b0;
	logic [2:0] i_mode = 3'h4, i_access_area = 3'h0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, o_rdata, o_area_width_bits, o_area_state_bits;
	logic i_wr = 1'b0, i_rd = 1'b0, i_access_external = 1'b0, slow = 1'b0, i_wait_request;
	logic o_access_8bit, o_wait_pin_enable;
	logic [1:0] o_access_states, o_access_waits;
	int regs [4];
	logic [7:0] status_exp = 8'h04;
	int num_errors = 0, checked = 0, cycles = 0;

	external_area_access_config uut (.i_clk(i_clk), .i_reset(i_reset), .i_hw_standby(i_hw_standby),
		.i_manual_reset(i_manual_reset), .i_sw_standby(i_sw_standby), .i_mode(i_mode), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_access_area(i_access_area),
		.i_access_external(i_access_external), .i_wait_request(i_wait_request), .o_rdata(o_rdata),
		.o_area_width_bits(o_area_width_bits), .o_area_state_bits(o_area_state_bits),
		.o_access_8bit(o_access_8bit), .o_access_states(o_access_states), .o_access_waits(o_access_waits),
		.o_wait_pin_enable(o_wait_pin_enable));
	ext_bus_model far (.i_wait_pin_enable(o_wait_pin_enable), .i_slow(slow), .o_wait_request(i_wait_request));

	// 10 MHz clock
	always #50 i_clk = ~i_clk;

	task automatic final_report();
		$display("checked=%0d num_errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	// Run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			final_report();
		end
	end

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8

	task automatic cmp_view(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch t=%0t view got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_view

	// Power-on and hardware standby defaults depend on the mode strap
	task automatic defaults();
		regs = '{i_mode == 3'h4 ? 32'h0 : 32'hFF, 32'hFF, 32'hFF, 32'hFF};
	endtask : defaults

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		regs[a[1:0]] = d;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		cmp8(o_rdata, a < 4'h4 ? regs[a[1:0]][7:0] : (a == 4'h4 ? status_exp : 8'h00));
	endtask : rd

	// Present one access and compare what the cycle generator would see
	task automatic view(input logic [2:0] n, input logic ext);
		int st;
		int wt;
		@(posedge i_clk);
		i_access_area <= n;
		i_access_external <= ext;
		slow <= 1'($urandom);
		@(posedge i_clk);
		#1;
		st = ext & regs[1][n];
		wt = n > 3'h3 ? regs[2] >> (2 * (n - 4)) : regs[3] >> (2 * n);
		cmp_view({o_access_8bit, o_access_states, o_access_waits, o_wait_pin_enable},
			{ext & regs[0][n], st ? 2'h3 : 2'h2, st ? wt[1:0] : 2'h0, st[0]});
	endtask : view

	initial
	begin
		void'($urandom(62373));
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		defaults();
		@(posedge i_clk);
		for (int a = 0; a < 6; a++)
			rd(a == 5 ? 4'hF : a[3:0]);
		repeat (60)
		begin
			wr(4'($urandom_range(3)), 8'($urandom));
			rd(4'($urandom_range(3)));
			view(3'($urandom), 1'($urandom));
		end
		for (int n = 0; n < 16; n++)
			view(n[2:0], n[3]);
		// Manual reset and software standby must leave the bank alone
		@(posedge i_clk);
		i_manual_reset <= 1'b1;
		i_sw_standby <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_manual_reset <= 1'b0;
		i_sw_standby <= 1'b0;
		for (int a = 0; a < 4; a++)
			rd(a[3:0]);
		// A slow device on a 3-state area shows in status once its request is synchronised
		wr(4'h1, 8'h80);
		i_access_area <= 3'h7;
		i_access_external <= 1'b1;
		slow <= 1'b1;
		repeat (6) @(posedge i_clk);
		status_exp = 8'h14;
		rd(4'h4);
		@(posedge i_clk);
		slow <= 1'b0;
		repeat (6) @(posedge i_clk);
		status_exp = 8'h04;
		rd(4'h4);
		// Hardware standby in mode 5 reloads every register and refuses writes
		@(posedge i_clk);
		i_mode <= 3'h5;
		i_hw_standby <= 1'b1;
		repeat (8) @(posedge i_clk);
		wr(4'h1, 8'h00);
		status_exp = 8'h0D;
		rd(4'h4);
		@(posedge i_clk);
		i_hw_standby <= 1'b0;
		repeat (6) @(posedge i_clk);
		defaults();
		status_exp = 8'h05;
		for (int a = 0; a < 5; a++)
			rd(a[3:0]);
		final_report();
	end
endmodule : tb
